// ---- verilog/sgc_pkg.sv ----
package sgc_pkg;

  // pin group widths
  localparam int ADDR_W  = 10;
  localparam int DATA_W  = 32;
  localparam int BYTES   = 4;

  // command pins plus byte masks, sampled together on every rising edge
  typedef struct packed {
    logic                cs_n;
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic                special_function_select;
    logic                bank_select;
    logic [ADDR_W-1:0]   addr;
    logic [BYTES-1:0]    byte_mask;
  } sgc_cmd_type;

  // burst engine states
  typedef enum logic [2:0] {
    ENG_IDLE  = 3'b001,
    ENG_READ  = 3'b010,
    ENG_WRITE = 3'b100
  } sgc_eng_type;

  // address bit that selects autoprecharge or all banks
  localparam int AUTO_PRE_BIT  = 9;
  localparam int ALL_BANKS_BIT = 9;

  // mode register layout (bits of the address pins at load time)
  localparam int MODE_W        = 9;
  localparam int MR_BL_LSB     = 0;
  localparam int MR_ORDER_BIT  = 3;
  localparam int MR_CL_LSB     = 4;
  localparam int MR_BRSW_BIT   = 7;
  localparam logic [MODE_W-1:0] MODE_RST = 9'h020;

  // burst length codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // read latency codes
  localparam logic [2:0] CL_1 = 3'h1;
  localparam logic [2:0] CL_2 = 3'h2;

  // register map, byte offsets
  localparam logic [7:0] REG_MASK_OFS   = 8'h00;
  localparam logic [7:0] REG_MODE_OFS   = 8'h04;
  localparam logic [7:0] REG_STATUS_OFS = 8'h08;
  localparam logic [31:0] MASK_RST      = 32'hffffffff;

  // status register fields
  localparam int ST_OPEN_LSB   = 0;
  localparam int ST_MASKEN_LSB = 2;
  localparam int ST_ENG_LSB    = 4;

endpackage

// ---- verilog/sgc_bank_core.sv ----
`timescale 1ns/1ps

module sgc_bank_core #(
  parameter int ROW_W = 10,
  parameter int COL_W = 8
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire sgc_pkg::sgc_cmd_type      cmd,
  input  wire logic [sgc_pkg::DATA_W-1:0] dq_in,
  output logic [sgc_pkg::DATA_W-1:0]     dq_out,
  output logic [sgc_pkg::BYTES-1:0]      dq_oe_n,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic [31:0]                    hrdata,
  output logic                           hresp
);

  localparam int MEM_AW = 1 + ROW_W + COL_W;

  // column of word n of a burst, in sequential or interleaved order
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [COL_W-1:0] n,
                                                 input logic [2:0]       code,
                                                 input logic             il);
    logic [COL_W-1:0] wrap;
    logic [COL_W-1:0] sum;
    begin
      case (code)
        sgc_pkg::BL_2:    wrap = COL_W'(1);
        sgc_pkg::BL_4:    wrap = COL_W'(3);
        sgc_pkg::BL_8:    wrap = COL_W'(7);
        sgc_pkg::BL_PAGE: wrap = '1;
        default:          wrap = '0;
      endcase
      sum = start + n;
      if (il && code != sgc_pkg::BL_PAGE) begin
        burst_col = start ^ (n & wrap);
      end else begin
        burst_col = (start & ~wrap) | (sum & wrap);
      end
    end
  endfunction

  // true when word n is the final word; full page never ends by itself unless one_word is set
  function automatic logic burst_last(input logic [COL_W-1:0] n,
                                      input logic [2:0]       code,
                                      input logic             one_word);
    begin
      if (one_word) begin
        burst_last = (n == '0);
      end else begin
        case (code)
          sgc_pkg::BL_2:    burst_last = (n == COL_W'(1));
          sgc_pkg::BL_4:    burst_last = (n == COL_W'(3));
          sgc_pkg::BL_8:    burst_last = (n == COL_W'(7));
          sgc_pkg::BL_PAGE: burst_last = 1'b0;
          default:          burst_last = (n == '0);
        endcase
      end
    end
  endfunction

  // storage: two banks of rows by columns
  // no reset on storage; contents after power-up carry no meaning anyway
  // shrink ROW_W and COL_W in simulation to keep this array small
  logic [sgc_pkg::DATA_W-1:0] mem [0:(2**MEM_AW)-1];

  // bank, mode and engine state
  logic [1:0]                  open_r;
  logic [1:0]                  mask_en_r;
  logic [ROW_W-1:0]            row_r [0:1];
  logic [sgc_pkg::MODE_W-1:0]  mode_r;
  logic [31:0]                 wmask_r;
  sgc_pkg::sgc_eng_type        eng_r;
  sgc_pkg::sgc_eng_type        eng_nxt;
  logic                        eng_bank_r;
  logic [COL_W-1:0]            start_r;
  logic [COL_W-1:0]            cnt_r;
  logic                        autopre_r;

  // read pipeline and output stage
  logic [sgc_pkg::DATA_W-1:0]  p0_d_r;
  logic [sgc_pkg::DATA_W-1:0]  p1_d_r;
  logic                        p0_v_r;
  logic                        p1_v_r;
  logic [sgc_pkg::BYTES-1:0]   mask_d1_r;
  logic [sgc_pkg::DATA_W-1:0]  dq_out_r;
  logic [sgc_pkg::BYTES-1:0]   dq_oe_n_r;

  // bus slave state
  logic                        a_vld_r;
  logic                        a_wr_r;
  logic [7:0]                  a_ofs_r;
  logic [31:0]                 hrdata_r;

  // command decode, all sampled on the clock edge only
  // block write only ends a burst here; its colour fill lives elsewhere
  wire sel        = ~cmd.cs_n;
  wire bank       = cmd.bank_select;
  wire is_act     = sel & ~cmd.ras_n & cmd.cas_n & cmd.we_n;
  wire is_pre     = sel & ~cmd.ras_n & cmd.cas_n & ~cmd.we_n & ~cmd.special_function_select;
  wire pre_all    = is_pre & cmd.addr[sgc_pkg::ALL_BANKS_BIT];
  wire is_rd      = sel & cmd.ras_n & ~cmd.cas_n & cmd.we_n & ~cmd.special_function_select;
  wire is_wr_any  = sel & cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;
  wire is_wr      = is_wr_any & ~cmd.special_function_select;
  wire is_mrs     = sel & ~cmd.ras_n & ~cmd.cas_n & ~cmd.we_n & ~cmd.special_function_select;

  // mode fields
  wire [2:0] bl_code  = mode_r[sgc_pkg::MR_BL_LSB +: 3];
  wire [2:0] cl_code  = mode_r[sgc_pkg::MR_CL_LSB +: 3];
  wire       order_il = mode_r[sgc_pkg::MR_ORDER_BIT];
  wire       brsw     = mode_r[sgc_pkg::MR_BRSW_BIT];

  // accesses only start on an open bank
  wire rd_go = is_rd & open_r[bank];
  wire wr_go = is_wr & open_r[bank];

  // any column command or a precharge hitting the burst bank ends the burst
  wire pre_hits = is_pre & (pre_all | (bank == eng_bank_r));
  wire cut      = is_rd | is_wr_any | pre_hits;

  wire rd_cont = (eng_r == sgc_pkg::ENG_READ) & ~cut;
  wire wr_cont = (eng_r == sgc_pkg::ENG_WRITE) & ~cut;

  // address of the word handled this cycle: new command or running burst
  wire              new_cmd = rd_go | wr_go;
  wire              acc_bk  = new_cmd ? bank : eng_bank_r;
  wire [COL_W-1:0]  acc_st  = new_cmd ? cmd.addr[COL_W-1:0] : start_r;
  wire [COL_W-1:0]  acc_n   = new_cmd ? '0 : cnt_r;
  wire [COL_W-1:0]  acc_col = burst_col(acc_st, acc_n, bl_code, order_il);
  wire [MEM_AW-1:0] acc_a   = {acc_bk, row_r[acc_bk], acc_col};
  wire              rd_now  = rd_go | rd_cont;
  wire              wr_now  = wr_go | wr_cont;
  wire              last_rd = burst_last(acc_n, bl_code, 1'b0);
  wire              last_wr = burst_last(acc_n, bl_code, brsw);
  wire              ap_now  = new_cmd ? cmd.addr[sgc_pkg::AUTO_PRE_BIT] : autopre_r;
  wire              ap_done = rd_now & last_rd & ap_now & (bl_code != sgc_pkg::BL_PAGE);

  // bit enables: byte masks always, mask register only on masked rows
  wire [31:0] byte_en = {{8{~cmd.byte_mask[3]}}, {8{~cmd.byte_mask[2]}},
                         {8{~cmd.byte_mask[1]}}, {8{~cmd.byte_mask[0]}}};
  wire [31:0] bit_en  = mask_en_r[acc_bk] ? wmask_r : '1;
  wire [31:0] wr_en   = byte_en & bit_en;
  wire [31:0] rd_word = mem[acc_a];

  // output word chosen by programmed read latency
  wire [31:0] out_d = (cl_code == sgc_pkg::CL_1) ? rd_word :
                      (cl_code == sgc_pkg::CL_2) ? p0_d_r : p1_d_r;
  wire        out_v = (cl_code == sgc_pkg::CL_1) ? rd_now :
                      (cl_code == sgc_pkg::CL_2) ? p0_v_r : p1_v_r;

  // engine next state
  // a cut or finished burst drops to idle on the same edge, so a new
  // command on that edge restarts the engine without a dead cycle
  always_comb begin
    eng_nxt = eng_r;
    case (eng_r)
      sgc_pkg::ENG_IDLE,
      sgc_pkg::ENG_READ,
      sgc_pkg::ENG_WRITE: begin
        if (rd_now) begin
          eng_nxt = last_rd ? sgc_pkg::ENG_IDLE : sgc_pkg::ENG_READ;
        end else if (wr_now) begin
          eng_nxt = last_wr ? sgc_pkg::ENG_IDLE : sgc_pkg::ENG_WRITE;
        end else begin
          eng_nxt = sgc_pkg::ENG_IDLE;
        end
      end
      default: eng_nxt = sgc_pkg::ENG_IDLE;
    endcase
  end

  // burst engine registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eng_r      <= sgc_pkg::ENG_IDLE;
      eng_bank_r <= 1'b0;
      start_r    <= '0;
      cnt_r      <= '0;
      autopre_r  <= 1'b0;
    end else begin
      eng_r      <= eng_nxt;
      eng_bank_r <= acc_bk;
      start_r    <= acc_st;
      cnt_r      <= acc_n + COL_W'(1);
      autopre_r  <= ap_now;
    end
  end

  // per-bank open and masking flags, rows latched with the activate
  always_ff @(posedge core_clk) begin
    if (rst) begin
      open_r    <= 2'h0;
      mask_en_r <= 2'h0;
    end else begin
      if (is_act && !open_r[bank]) begin
        open_r[bank]    <= 1'b1;
        mask_en_r[bank] <= cmd.special_function_select;
      end
      // masking flag goes with the row, so a closed bank forgets it
      if (pre_all) begin
        open_r    <= 2'h0;
        mask_en_r <= 2'h0;
      end else if (is_pre) begin
        open_r[bank]    <= 1'b0;
        mask_en_r[bank] <= 1'b0;
      end
      if (ap_done) begin
        open_r[acc_bk]    <= 1'b0;
        mask_en_r[acc_bk] <= 1'b0;
      end
    end
  end

  // row latch needs no reset; a closed bank never reads it
  always_ff @(posedge core_clk) begin
    if (is_act && !open_r[bank]) begin
      row_r[bank] <= cmd.addr[ROW_W-1:0];
    end
  end

  // mode register loads only with both banks idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_r <= sgc_pkg::MODE_RST;
    end else if (is_mrs && open_r == 2'h0) begin
      mode_r <= cmd.addr[sgc_pkg::MODE_W-1:0];
    end
  end

  // masked read-modify-write of one word per write cycle
  always_ff @(posedge core_clk) begin
    if (wr_now) begin
      mem[acc_a] <= (rd_word & ~wr_en) | (dq_in & wr_en);
    end
  end

  // read latency pipeline; words in flight still leave after a cut
  // both stages always run, so a latency change needs no flush
  always_ff @(posedge core_clk) begin
    if (rst) begin
      p0_v_r    <= 1'b0;
      p1_v_r    <= 1'b0;
      mask_d1_r <= '1;
      dq_oe_n_r <= '1;
    end else begin
      p0_v_r    <= rd_now;
      p1_v_r    <= p0_v_r;
      mask_d1_r <= cmd.byte_mask;
      dq_oe_n_r <= ~({sgc_pkg::BYTES{out_v}} & ~mask_d1_r);
    end
  end

  // data stages load every cycle, the output holds its last word; the enable decides visibility
  always_ff @(posedge core_clk) begin
    p0_d_r <= rd_word;
    p1_d_r <= p0_d_r;
    if (rst) begin
      dq_out_r <= '0;
    end else if (out_v) begin
      dq_out_r <= out_d;
    end
  end

  assign dq_out  = dq_out_r;
  assign dq_oe_n = dq_oe_n_r;

  // bus slave: zero wait state, always okay
  // hsize is not decoded; only whole-word transfers are expected here
  // register reads are prepared in the address phase, so hrdata is a flop
  wire        a_take  = hsel & htrans[1] & hready;
  wire        fwd     = a_vld_r & a_wr_r & (a_ofs_r == haddr[7:0]);
  wire [31:0] status  = {25'h0, eng_r, mask_en_r, open_r};
  wire [31:0] rd_mux  = (haddr[7:0] == sgc_pkg::REG_MASK_OFS)   ? (fwd ? hwdata : wmask_r) :
                        (haddr[7:0] == sgc_pkg::REG_MODE_OFS)   ? {23'h0, mode_r} :
                        (haddr[7:0] == sgc_pkg::REG_STATUS_OFS) ? status : 32'h0;

  // address phase capture and read data preparation
  always_ff @(posedge core_clk) begin
    if (rst) begin
      a_vld_r  <= 1'b0;
      a_wr_r   <= 1'b0;
      a_ofs_r  <= 8'h00;
      hrdata_r <= 32'h0;
    end else begin
      a_vld_r <= a_take;
      a_wr_r  <= hwrite;
      a_ofs_r <= haddr[7:0];
      if (a_take && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // write data phase; only the mask register is writable
  // mode and status stay read-only: mode changes only by command
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wmask_r <= sgc_pkg::MASK_RST;
    end else if (a_vld_r && a_wr_r && a_ofs_r == sgc_pkg::REG_MASK_OFS) begin
      wmask_r <= hwdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hrdata    = hrdata_r;
  assign hresp     = 1'b0;

endmodule

// ---- sim/sgc_bank_core_checker.sv ----
`timescale 1ns/1ps
module sgc_bank_core_checker (
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire sgc_pkg::sgc_cmd_type       cmd,
  input wire logic [sgc_pkg::DATA_W-1:0] dq_out,
  input wire logic [sgc_pkg::BYTES-1:0]  dq_oe_n,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic [31:0]                hrdata,
  input wire logic                       hresp
);
  logic [2:0] rd_hist_r;
  wire logic  rd_cmd = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && cmd.we_n;
  wire logic  ahb_rd = hsel && htrans[1] && hready && !hwrite;

  // reads seen on the last three edges; latency tops out at three
  always_ff @(posedge core_clk) begin
    rd_hist_r <= {rd_hist_r[1:0], rd_cmd};
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_float: assert property (disable iff (1'b0) rst |=> dq_oe_n == 4'hf && dq_out == '0)
    else $error("data pins driven after reset");
  a_oe_cause: assert property (dq_oe_n != 4'hf |-> $past(dq_oe_n) != 4'hf || rd_hist_r != 3'h0)
    else $error("data pins driven without a read");
  a_mask_latency: assert property (dq_oe_n != 4'hf |-> dq_oe_n == $past(cmd.byte_mask, 2))
    else $error("byte enable not two clocks after mask");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("bus wait state inserted");
  a_okay_resp: assert property (hresp == 1'b0)
    else $error("bus error response");
  a_unmapped_zero: assert property (ahb_rd && haddr == 32'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_engine_onehot: assert property (ahb_rd && haddr == 32'h8 |=> $onehot(hrdata[6:4]))
    else $error("engine state not one-hot");
  a_rdata_hold: assert property (!ahb_rd |=> $stable(hrdata))
    else $error("read data moved without a read");

  c_read_word: cover property (rd_cmd ##2 dq_oe_n == 4'h0);
  c_status_read: cover property (ahb_rd && haddr == 32'h8);
  c_write_cmd: cover property (!cmd.cs_n && cmd.ras_n && !cmd.cas_n && !cmd.we_n);
endmodule

bind sgc_bank_core sgc_bank_core_checker u_chk (.core_clk(core_clk), .rst(rst), .cmd(cmd),
  .dq_out(dq_out), .dq_oe_n(dq_oe_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

// ---- sim/sgc_ctrl_model.sv ----
`timescale 1ns/1ps
module sgc_ctrl_model (
  input  wire logic                  core_clk,
  output sgc_pkg::sgc_cmd_type       cmd,
  output logic [sgc_pkg::DATA_W-1:0] dq_in
);
  // deselected until the first command
  initial begin
    cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 10'h0, 4'h0};
    dq_in = '0;
  end

  // one command with two data words, then nops; caller sets the idle gap
  task automatic issue(input logic [3:0] op, input logic sfs, bank, input logic [9:0] a,
                       input logic [3:0] bm, input logic [31:0] w0, w1, input int idle);
    @(posedge core_clk);
    cmd <= '{op[3], op[2], op[1], op[0], sfs, bank, a, bm};
    dq_in <= w0;
    @(posedge core_clk);
    cmd <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 10'h0, 4'h0};
    dq_in <= w1;
    @(posedge core_clk);
    dq_in <= ~w1; // released line must not show the old word
    repeat (idle) @(posedge core_clk);
  endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] RD  = 4'h5;
  localparam logic [3:0] WR  = 4'h4;
  logic                 core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, ahb_dp;
  logic [31:0]          haddr, hwdata, hrdata, seed, dq_in, dq_out;
  logic [31:0]          w[6];
  logic [31:0]          exp_q[$];
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [3:0]           dq_oe_n;
  sgc_pkg::sgc_cmd_type cmd;
  int                   miscompares, comparisons, cycles;

  assign hready = hreadyout;
  sgc_bank_core uut (.core_clk(core_clk), .rst(rst), .cmd(cmd), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  sgc_ctrl_model u_ctrl (.core_clk(core_clk), .cmd(cmd), .dq_in(dq_in));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // single word transfer; never assumes the slave answers at once
  task automatic ahb(input logic wr, input logic [31:0] a, d, want);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    if (!wr) exp_q.push_back(want);
    ahb_dp <= !wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    ahb_dp <= 1'b0;
  endtask

  // a word on the pins or a bus read data phase retires the oldest note
  always @(negedge core_clk) begin
    if (!rst && (dq_oe_n !== 4'hf || ahb_dp)) begin
      if (exp_q.size() == 0)
        check({28'h0, dq_oe_n}, 32'hf);
      else
        check(ahb_dp ? hrdata : dq_out, exp_q.pop_front());
    end
  end

  // hang guard, far above the under two hundred cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    seed = 32'h2a87;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    ahb_dp = 1'b0;
    foreach (w[i]) w[i] = $random(seed);
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    ahb(1'b0, 32'h0, '0, 32'hffffffff);
    ahb(1'b0, 32'h4, '0, 32'h020);
    ahb(1'b0, 32'h10, '0, 32'h0);
    u_ctrl.issue(4'h0, 1'b0, 1'b0, 10'h021, 4'h0, '0, '0, 2);
    ahb(1'b0, 32'h4, '0, 32'h021);
    u_ctrl.issue(ACT, 1'b0, 1'b0, 10'h155, 4'h0, '0, '0, 4);
    u_ctrl.issue(ACT, 1'b1, 1'b1, 10'h2aa, 4'h0, '0, '0, 4);
    ahb(1'b0, 32'h8, '0, 32'h1b);
    u_ctrl.issue(WR, 1'b0, 1'b1, 10'h000, 4'h0, w[0], w[1], 4);
    ahb(1'b1, 32'h0, 32'h00ff00ff, '0);
    u_ctrl.issue(WR, 1'b0, 1'b1, 10'h000, 4'h1, w[2], w[3], 4);
    u_ctrl.issue(WR, 1'b0, 1'b0, 10'h0fe, 4'h0, w[4], w[5], 4);
    exp_q.push_back(w[4]);
    exp_q.push_back(w[5]);
    u_ctrl.issue(RD, 1'b0, 1'b0, 10'h0fe, 4'h0, '0, '0, 4);
    exp_q.push_back(w[5]);
    exp_q.push_back(w[4]);
    u_ctrl.issue(RD, 1'b0, 1'b0, 10'h2ff, 4'h0, '0, '0, 4);
    ahb(1'b0, 32'h8, '0, 32'h1a);
    exp_q.push_back({w[0][31:24], w[2][23:16], w[0][15:8], w[0][7:0]});
    exp_q.push_back({w[1][31:24], w[3][23:16], w[1][15:8], w[3][7:0]});
    u_ctrl.issue(RD, 1'b0, 1'b1, 10'h000, 4'h4, '0, '0, 4);
    u_ctrl.issue(PRE, 1'b0, 1'b0, 10'h200, 4'h0, '0, '0, 4);
    ahb(1'b0, 32'h8, '0, 32'h10);
    u_ctrl.issue(RD, 1'b0, 1'b1, 10'h000, 4'h0, '0, '0, 4);
    u_ctrl.issue(4'h0, 1'b0, 1'b0, 10'h091, 4'h0, '0, '0, 2);
    ahb(1'b0, 32'h4, '0, 32'h091);
    u_ctrl.issue(ACT, 1'b0, 1'b0, 10'h155, 4'h0, '0, '0, 4);
    u_ctrl.issue(WR, 1'b0, 1'b0, 10'h0fe, 4'h0, w[2], w[3], 4);
    exp_q.push_back(w[2]);
    exp_q.push_back(w[5]);
    u_ctrl.issue(RD, 1'b0, 1'b0, 10'h0fe, 4'h0, '0, '0, 4);
    check(exp_q.size(), 32'h0);
    wrap_up();
  end
endmodule
